// *** src/gx_expander.sv ***
`timescale 1ns/100ps
module gx_expander #(
    parameter int PORT_W = gx_pkg::PORT_W
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic [gx_pkg::STRAP_W-1:0] addr_strap_i,
    input wire logic [PORT_W-1:0] port_pin_i,
    output logic [PORT_W-1:0] port_pin_o,
    output logic [PORT_W-1:0] port_pin_oe_n_o,
    output logic alert_o,
    output logic alert_oe_n_o
);
    gx_pkg::gx_i2c_s raw_s;
    gx_pkg::gx_i2c_s filt_s;
    gx_pkg::gx_i2c_s prev_r;
    gx_pkg::gx_cfg_s cfg_r;
    gx_pkg::gx_state_e st_r;
    logic [PORT_W-1:0] pin_s;
    logic [PORT_W-1:0] in_reg_r;
    logic [gx_pkg::STRAP_W-1:0] strap_s;
    logic [1:0] ptr_r;
    logic [7:0] shift_r;
    logic [3:0] cnt_r;
    logic rw_r;
    logic nack_r;
    logic init_done_r;
    logic [1:0] init_cnt_r;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic byte_end;
    logic addr_hit;
    logic mism;
    logic [7:0] rd_data;

    gx_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i({scl_i, sda_i}),
        .q_o(raw_s)
    );

    gx_glitch #(.DEPTH(gx_pkg::SPIKE_CYC), .RST_VAL(1'b1)) u_scl_filt (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(raw_s.scl),
        .q_o(filt_s.scl)
    );

    gx_glitch #(.DEPTH(gx_pkg::SPIKE_CYC), .RST_VAL(1'b1)) u_sda_filt (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(raw_s.sda),
        .q_o(filt_s.sda)
    );

    gx_sync #(.W(PORT_W), .RST_VAL({PORT_W{1'b1}})) u_pin_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(port_pin_i),
        .q_o(pin_s)
    );

    // straps are only compared, so stability across a frame is the system's job
    gx_sync #(.W(gx_pkg::STRAP_W), .RST_VAL('0)) u_strap_sync (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .d_i(addr_strap_i),
        .q_o(strap_s)
    );

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev_r <= '1;
        end else begin
            prev_r <= filt_s;
        end
    end

    // line changes with scl high are framing
    assign start_det = prev_r.scl && filt_s.scl && prev_r.sda && !filt_s.sda;
    assign stop_det = prev_r.scl && filt_s.scl && !prev_r.sda && filt_s.sda;
    assign scl_rise = !prev_r.scl && filt_s.scl;
    assign scl_fall = prev_r.scl && !filt_s.scl;
    assign byte_end = scl_fall && (cnt_r == gx_pkg::BITS_PER_BYTE);

    assign addr_hit = (shift_r[7:1] == {gx_pkg::ADDR_PREFIX, strap_s});

    // polarity applies to reported input only
    always_comb begin
        unique case (ptr_r)
            gx_pkg::PTR_INPUT: rd_data = pin_s ^ cfg_r.pol;
            gx_pkg::PTR_OUTPUT: rd_data = cfg_r.outp;
            gx_pkg::PTR_POLARITY: rd_data = cfg_r.pol;
            gx_pkg::PTR_DIRECTION: rd_data = cfg_r.dir;
        endcase
    end

    // bus state machine, shifter and sda drive
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_r <= gx_pkg::ST_IDLE;
            shift_r <= 8'h00;
            cnt_r <= 4'h0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sda_oe_n_o <= 1'b1;
            sda_o <= 1'b0;
        end else if (stop_det) begin
            st_r <= gx_pkg::ST_IDLE;
            sda_oe_n_o <= 1'b1;
        end else if (start_det) begin
            st_r <= gx_pkg::ST_ADDR;
            cnt_r <= 4'h0;
            sda_oe_n_o <= 1'b1;
        end else begin
            unique case (st_r)
                gx_pkg::ST_IDLE: begin
                    sda_oe_n_o <= 1'b1;
                end
                gx_pkg::ST_ADDR, gx_pkg::ST_CMD, gx_pkg::ST_WDATA: begin
                    // msb first, one bit per pulse
                    if (scl_rise) begin
                        shift_r <= {shift_r[6:0], filt_s.sda};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (byte_end) begin
                        cnt_r <= 4'h0;
                        if (st_r != gx_pkg::ST_ADDR) begin
                            sda_oe_n_o <= 1'b0;
                            st_r <= (st_r == gx_pkg::ST_CMD) ? gx_pkg::ST_CACK : gx_pkg::ST_WACK;
                        end else if (addr_hit) begin
                            sda_oe_n_o <= 1'b0;
                            rw_r <= shift_r[0];
                            st_r <= gx_pkg::ST_AACK;
                        end else begin
                            st_r <= gx_pkg::ST_IDLE;
                        end
                    end
                end
                gx_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        if (rw_r) begin
                            shift_r <= rd_data;
                            sda_oe_n_o <= rd_data[7];
                            st_r <= gx_pkg::ST_RDATA;
                        end else begin
                            sda_oe_n_o <= 1'b1;
                            st_r <= gx_pkg::ST_CMD;
                        end
                    end
                end
                gx_pkg::ST_CACK, gx_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        sda_oe_n_o <= 1'b1;
                        st_r <= gx_pkg::ST_WDATA;
                    end
                end
                gx_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_r <= cnt_r + 4'h1;
                    end else if (byte_end) begin
                        cnt_r <= 4'h0;
                        sda_oe_n_o <= 1'b1;
                        st_r <= gx_pkg::ST_RACK;
                    end else if (scl_fall) begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        sda_oe_n_o <= shift_r[6];
                    end
                end
                gx_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        nack_r <= filt_s.sda;
                    end else if (scl_fall) begin
                        if (nack_r) begin
                            // nack ends read, line stays released
                            st_r <= gx_pkg::ST_IDLE;
                        end else begin
                            shift_r <= rd_data;
                            sda_oe_n_o <= rd_data[7];
                            st_r <= gx_pkg::ST_RDATA;
                        end
                    end
                end
                default: begin
                    st_r <= gx_pkg::ST_IDLE;
                    sda_oe_n_o <= 1'b1;
                end
            endcase
        end
    end

    // pointer and configuration registers
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ptr_r <= gx_pkg::PTR_RST;
            cfg_r.outp <= gx_pkg::OUTPUT_RST;
            cfg_r.pol <= gx_pkg::POLARITY_RST;
            cfg_r.dir <= gx_pkg::DIRECTION_RST;
        end else if (byte_end && !start_det && !stop_det) begin
            if (st_r == gx_pkg::ST_CMD) begin
                ptr_r <= shift_r[1:0];
            end else if (st_r == gx_pkg::ST_WDATA) begin
                unique case (ptr_r)
                    gx_pkg::PTR_INPUT: ;
                    gx_pkg::PTR_OUTPUT: cfg_r.outp <= shift_r;
                    gx_pkg::PTR_POLARITY: cfg_r.pol <= shift_r;
                    gx_pkg::PTR_DIRECTION: cfg_r.dir <= shift_r;
                endcase
            end
        end
    end

    // input register: caught on each of the first four cycles after reset, then on each read ack of the input register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            in_reg_r <= '1;
            init_cnt_r <= 2'h0;
            init_done_r <= 1'b0;
        end else if (!init_done_r) begin
            in_reg_r <= pin_s;
            init_cnt_r <= init_cnt_r + 2'h1;
            init_done_r <= (init_cnt_r == gx_pkg::INIT_CYC);
        end else if (st_r == gx_pkg::ST_RACK && scl_rise && !stop_det && !start_det
                     && ptr_r == gx_pkg::PTR_INPUT) begin
            // clear at ack after scl rise; edges in this cycle are absorbed
            in_reg_r <= pin_s;
        end
    end

    // compare pins against latched input register
    // stale input register after direction change can alert
    assign mism = |((pin_s ^ in_reg_r) & cfg_r.dir);

    // level follows mismatch, so return or read clears it
    // open drain: only the enable moves
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alert_oe_n_o <= 1'b1;
            alert_o <= 1'b0;
        end else begin
            alert_oe_n_o <= !(mism && init_done_r);
            alert_o <= 1'b0;
        end
    end

    // input pins have both drivers off
    assign port_pin_o = cfg_r.outp;
    assign port_pin_oe_n_o = cfg_r.dir;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_addr_match;
        st_r == gx_pkg::ST_ADDR && byte_end && addr_hit;
    endsequence

    sequence s_read_nack;
        st_r == gx_pkg::ST_RACK && nack_r && scl_fall;
    endsequence

    property p_alert_valid;
        (mism && init_done_r)[*2] |-> !alert_oe_n_o;
    endproperty
    a_alert_valid: assert property (p_alert_valid) else $error("alert missing after mismatch");
    property p_no_false_alert;
        (!mism)[*2] |-> alert_oe_n_o;
    endproperty
    a_no_false_alert: assert property (p_no_false_alert) else $error("alert without mismatch");
    property p_outputs_quiet;
        (cfg_r.dir == 8'h00)[*3] |-> alert_oe_n_o;
    endproperty
    a_outputs_quiet: assert property (p_outputs_quiet) else $error("output pin raised alert");
    property p_alert_od;
        !alert_oe_n_o |-> !alert_o;
    endproperty
    a_alert_od: assert property (p_alert_od) else $error("alert driven high");

    property p_addr_ack;
        s_addr_match and !start_det and !stop_det |=> !sda_oe_n_o && st_r == gx_pkg::ST_AACK;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
    property p_nack_release;
        s_read_nack and !start_det and !stop_det |=> sda_oe_n_o && st_r == gx_pkg::ST_IDLE;
    endproperty
    a_nack_release: assert property (p_nack_release) else $error("sda held after nack");
    property p_ptr_stable;
        st_r == gx_pkg::ST_WDATA |=> $stable(ptr_r);
    endproperty
    a_ptr_stable: assert property (p_ptr_stable) else $error("pointer moved in data phase");
    property p_read_clear;
        st_r == gx_pkg::ST_RACK && scl_rise && !start_det && !stop_det && ptr_r == gx_pkg::PTR_INPUT
            && init_done_r |=> in_reg_r == $past(pin_s) ##2 (alert_oe_n_o || mism);
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear alert");

    property p_dir_write;
        st_r == gx_pkg::ST_WDATA && byte_end && !start_det && !stop_det && ptr_r == gx_pkg::PTR_DIRECTION
            |=> cfg_r.dir == $past(shift_r) ##1 port_pin_oe_n_o == $past(shift_r, 2);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("direction write lost");
    property p_start_addr;
        start_det && !stop_det |=> st_r == gx_pkg::ST_ADDR && sda_oe_n_o && cnt_r == 4'h0;
    endproperty
    a_start_addr: assert property (p_start_addr) else $error("start not taken");

    property p_input_inv;
        st_r == gx_pkg::ST_AACK && scl_fall && rw_r && ptr_r == gx_pkg::PTR_INPUT && !start_det && !stop_det
            |=> shift_r == $past(pin_s ^ cfg_r.pol);
    endproperty
    a_input_inv: assert property (p_input_inv) else $error("input polarity wrong");

endmodule

// *** src/gx_glitch.sv ***
`timescale 1ns/100ps
module gx_glitch #(
    parameter int DEPTH = 2,
    parameter logic RST_VAL = 1'b1
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic d_i,
    output logic q_o
);
    logic [DEPTH:0] hist_r;

    // level changes only after DEPTH+1 equal samples
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hist_r <= {(DEPTH + 1){RST_VAL}};
            q_o <= RST_VAL;
        end else begin
            hist_r <= {hist_r[DEPTH-1:0], d_i};
            if (&hist_r) begin
                q_o <= 1'b1;
            end else if (~|hist_r) begin
                q_o <= 1'b0;
            end
        end
    end
endmodule

// *** src/gx_pkg.sv ***
package gx_pkg;

    localparam int CLK_HZ = 25_000_000;
    localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

    // spike suppression on the two bus lines
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;

    // longest pin-edge to alert latency
    localparam int ALERT_VALID_DELAY_NS = 4000;
    localparam int ALERT_VALID_DELAY_CYC = ALERT_VALID_DELAY_NS / CLK_NS;

    localparam int PORT_W = 8;
    localparam int STRAP_W = 3;

    localparam logic [3:0] ADDR_PREFIX = 4'h4;

    localparam logic [1:0] PTR_INPUT = 2'h0;
    localparam logic [1:0] PTR_OUTPUT = 2'h1;
    localparam logic [1:0] PTR_POLARITY = 2'h2;
    localparam logic [1:0] PTR_DIRECTION = 2'h3;

    localparam logic [7:0] OUTPUT_RST = 8'hFF;
    localparam logic [7:0] POLARITY_RST = 8'h00;
    localparam logic [7:0] DIRECTION_RST = 8'hFF;
    localparam logic [1:0] PTR_RST = 2'h0;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] INIT_CYC = 2'h3;

    typedef struct packed {
        logic [7:0] outp;
        logic [7:0] pol;
        logic [7:0] dir;
    } gx_cfg_s;

    typedef struct packed {
        logic scl;
        logic sda;
    } gx_i2c_s;

    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_AACK  = 9'h004,
        ST_CMD   = 9'h008,
        ST_CACK  = 9'h010,
        ST_WDATA = 9'h020,
        ST_WACK  = 9'h040,
        ST_RDATA = 9'h080,
        ST_RACK  = 9'h100
    } gx_state_e;

endpackage

// *** src/gx_sync.sv ***
`timescale 1ns/100ps
module gx_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic sys_clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_r <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// *** test/gx_ctrl_model.sv ***
`timescale 1ns/100ps
module gx_ctrl_model (
    input wire logic sys_clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    // both lines released while the bus is idle
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic start();
        cyc(5);
        sda_o <= 1'h1;
        cyc(5);
        scl_o <= 1'h1;
        cyc(10);
        sda_o <= 1'h0;
        cyc(10);
        scl_o <= 1'h0;
    endtask
    // data moves only while scl low
    // long phases: the target sees both lines several cycles late
    task automatic bit_io(input logic b, output logic r);
        cyc(5);
        sda_o <= b;
        cyc(5);
        scl_o <= 1'h1;
        cyc(10);
        r = sda_i;
        scl_o <= 1'h0;
    endtask
    // msb first, ninth bit is acknowledge
    task automatic xfer(input logic [7:0] d, input logic last_b, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last_b, a);
    endtask
    task automatic stop();
        cyc(5);
        sda_o <= 1'h0;
        cyc(5);
        scl_o <= 1'h1;
        cyc(10);
        sda_o <= 1'h1;
        cyc(20);
    endtask
endmodule

// *** test/gx_expander_bench.sv ***
`timescale 1ns/100ps
module gx_expander_bench;
    logic sys_clk_i = 1'h0;
    logic arst_n_i = 1'h0;
    logic [gx_pkg::STRAP_W-1:0] strap = 3'h0;
    logic [7:0] ext_pin = 8'hFF;
    logic scl, sda_m, sda_o, sda_oe_n, alert_o, alert_oe_n;
    logic [7:0] pin_o, pin_oe_n;
    wire logic sda_w;
    wire logic alert_w;
    wire logic [7:0] pin_w;
    int error_cnt = 0;
    int n_compared = 0;
    always #20 sys_clk_i = ~sys_clk_i;
    // pull-ups on both open-drain lines
    assign sda_w = sda_m & (sda_oe_n | sda_o);
    assign alert_w = alert_oe_n | alert_o;
    assign pin_w = (pin_oe_n & ext_pin) | (~pin_oe_n & pin_o);
    gx_ctrl_model i_gx_ctrl_model (.sys_clk_i(sys_clk_i), .sda_i(sda_w), .scl_o(scl), .sda_o(sda_m));
    gx_expander i_gx_expander (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .addr_strap_i(strap), .port_pin_i(pin_w),
        .port_pin_o(pin_o), .port_pin_oe_n_o(pin_oe_n), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n));
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic wait_alert(input logic exp);
        int i;
        i = 0;
        while (alert_w !== exp && i < gx_pkg::ALERT_VALID_DELAY_CYC) begin
            @(posedge sys_clk_i);
            i++;
        end
        n_compared++;
        if (alert_w !== exp) begin
            $display("ERROR %0t alert %h exp %h", $time, alert_w, exp);
            error_cnt++;
            report_and_stop();
        end
    endtask
    task automatic addr(input logic [3:0] pre, input logic rw, input logic exp_a);
        logic [7:0] q;
        logic a;
        i_gx_ctrl_model.start();
        i_gx_ctrl_model.xfer({pre, strap, rw}, 1'h1, q, a);
        chk({7'h00, a}, {7'h00, exp_a});
    endtask
    task automatic wr(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1, input int n);
        logic [7:0] q;
        logic a;
        addr(gx_pkg::ADDR_PREFIX, 1'h0, 1'h0);
        i_gx_ctrl_model.xfer(p, 1'h1, q, a);
        chk({7'h00, a}, 8'h00);
        if (n > 0) i_gx_ctrl_model.xfer(d0, 1'h1, q, a);
        if (n > 1) i_gx_ctrl_model.xfer(d1, 1'h1, q, a);
        chk({7'h00, a}, 8'h00);
        i_gx_ctrl_model.stop();
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        logic [7:0] q;
        logic a;
        wr(p, 8'h00, 8'h00, 0);
        addr(gx_pkg::ADDR_PREFIX, 1'h1, 1'h0);
        i_gx_ctrl_model.xfer(8'hFF, 1'h0, q, a);
        chk(q, exp);
        i_gx_ctrl_model.xfer(8'hFF, 1'h1, q, a);
        chk(q, exp);
        i_gx_ctrl_model.stop();
    endtask
    task automatic t_reset();
        logic [23:0] rst_tbl;
        rst_tbl = {gx_pkg::DIRECTION_RST, gx_pkg::POLARITY_RST, gx_pkg::OUTPUT_RST};
        @(posedge sys_clk_i) arst_n_i <= 1'h0;
        i_gx_ctrl_model.cyc(6);
        arst_n_i <= 1'h1;
        i_gx_ctrl_model.cyc(12);
        chk(pin_oe_n, 8'hFF);
        chk(pin_o, 8'hFF);
        chk({5'h00, alert_w, alert_o, sda_oe_n}, 8'h05);
        for (int p = 1; p < 4; p++) begin
            rd(8'(p), rst_tbl[8*(p-1) +: 8]);
        end
        rd(8'h00, ext_pin);
        $display("done t_reset");
    endtask
    task automatic t_regs();
        wr(8'h01, 8'hA5, 8'h3C, 2);
        chk(pin_o, 8'h3C);
        wr(8'h03, 8'h0F, 8'h00, 1);
        chk(pin_oe_n, 8'h0F);
        chk({pin_w[7:4], 4'h0}, 8'h30);
        rd(8'h01, 8'h3C);
        wr(8'h03, 8'hFF, 8'h00, 1);
        $display("done t_regs");
    endtask
    task automatic t_pol();
        @(posedge sys_clk_i) ext_pin <= 8'hC3;
        wait_alert(1'h0);
        wr(8'h02, 8'hF0, 8'h00, 1);
        rd(8'h00, 8'h33);
        wait_alert(1'h1);
        wr(8'h02, 8'h00, 8'h00, 1);
        $display("done t_pol");
    endtask
    task automatic t_alert();
        @(posedge sys_clk_i) ext_pin <= 8'hC2;
        wait_alert(1'h0);
        @(posedge sys_clk_i) ext_pin <= 8'hC3;
        wait_alert(1'h1);
        @(posedge sys_clk_i) ext_pin <= 8'hC7;
        wait_alert(1'h0);
        addr(4'h5, 1'h0, 1'h1);
        i_gx_ctrl_model.stop();
        chk({7'h00, alert_w}, 8'h00);
        rd(8'h00, 8'hC7);
        wait_alert(1'h1);
        wr(8'h03, 8'hFE, 8'h00, 1);
        wr(8'h01, 8'h00, 8'h00, 1);
        @(posedge sys_clk_i) ext_pin <= 8'hC6;
        i_gx_ctrl_model.cyc(gx_pkg::ALERT_VALID_DELAY_CYC);
        chk({7'h00, alert_w}, 8'h01);
        wr(8'h03, 8'hFF, 8'h00, 1);
        wait_alert(1'h0);
        rd(8'h00, 8'hC6);
        wait_alert(1'h1);
        $display("done t_alert");
    endtask
    task automatic t_strap();
        for (logic [3:0] s = 4'h0; s < 4'h8; s++) begin
            // straps change only on an idle bus
            strap <= s[2:0];
            i_gx_ctrl_model.cyc(5);
            addr(gx_pkg::ADDR_PREFIX, 1'h0, 1'h0);
            i_gx_ctrl_model.stop();
            addr(4'h6, 1'h0, 1'h1);
            i_gx_ctrl_model.stop();
        end
        $display("done t_strap");
    endtask
    initial begin
        t_reset();
        t_regs();
        t_pol();
        t_alert();
        t_strap();
        t_reset();
        report_and_stop();
    end
endmodule
